/* core/dprp_pkg.sv */
// constants and helpers shared by the reference profile register bank
// assumes a 32-bit word per register, byte address equal to four times the index
package dprp_pkg;

	localparam int NUM_LOOPS = 2;
	localparam int BANK_SLOTS = 16;
	localparam int NUM_REFS = 4;

	// register indices for loop zero
	localparam logic [11:0] IDX_BANK_BASE = 12'h464;
	localparam logic [11:0] IDX_REF3_DEN_B0 = 12'h464;
	localparam logic [11:0] IDX_REF3_DEN_B1 = 12'h465;
	localparam logic [11:0] IDX_REF3_DEN_B2 = 12'h466;
	localparam logic [11:0] IDX_REF4_PRIO_EN = 12'h467;
	localparam logic [11:0] IDX_REF4_BW_B0 = 12'h468;
	localparam logic [11:0] IDX_REF4_BW_B1 = 12'h469;
	localparam logic [11:0] IDX_REF4_BW_B2_FILT = 12'h46a;
	localparam logic [11:0] IDX_REF4_INT_B0 = 12'h46b;
	localparam logic [11:0] IDX_REF4_INT_B1 = 12'h46c;
	localparam logic [11:0] IDX_REF4_INT_B2 = 12'h46d;
	localparam logic [11:0] IDX_REF4_NUM_B0 = 12'h46e;
	localparam logic [11:0] IDX_REF4_NUM_B1 = 12'h46f;
	localparam logic [11:0] IDX_REF4_NUM_B2 = 12'h470;
	localparam logic [11:0] IDX_REF4_DEN_B0 = 12'h471;
	localparam logic [11:0] IDX_REF4_DEN_B1 = 12'h472;
	localparam logic [11:0] IDX_REF4_DEN_B2 = 12'h473;
	localparam logic [11:0] IDX_LOOP_STATUS = 12'h47f;
	localparam logic [11:0] IDX_LOOP_STRIDE = 12'h100;

	// slot positions inside one loop bank
	localparam int SLOT_REF3_DEN_B0 = 0;
	localparam int SLOT_PRIO_EN = 3;
	localparam int SLOT_BW_B0 = 4;
	localparam int SLOT_BW_B1 = 5;
	localparam int SLOT_BW_B2 = 6;
	localparam int SLOT_INT_B0 = 7;
	localparam int SLOT_INT_B1 = 8;
	localparam int SLOT_INT_B2 = 9;
	localparam int SLOT_NUM_B0 = 10;
	localparam int SLOT_DEN_B0 = 13;

	// field positions
	localparam int POS_ENABLE = 0;
	localparam int POS_PRIO_LO = 1;
	localparam int POS_BW_TOP = 0;
	localparam int POS_FILTER_SEL = 1;
	localparam int REF4_INDEX = 3;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] MASK_PRIO_EN = 8'h07;
	localparam logic [7:0] MASK_TWO_BITS = 8'h03;
	localparam logic [7:0] MASK_FULL = 8'hff;

	// writable bits of a slot; reserved bits stay zero
	function automatic logic [7:0] slot_mask(input int slot);
		logic [7:0] m;
		m = MASK_FULL;
		if (slot == SLOT_PRIO_EN)
			m = MASK_PRIO_EN;
		else if (slot == SLOT_BW_B2 || slot == SLOT_INT_B2)
			m = MASK_TWO_BITS;
		return m;
	endfunction : slot_mask

endpackage : dprp_pkg

/* core/dprp_ref_select.sv */
// picks the reference a loop tracks among enabled, valid references
// assumes all inputs come from logic on the same clock
`timescale 1ns/10ps
module dprp_ref_select #(
	parameter int NREF = 4
) (
	input wire logic [NREF-1:0] enable_i,
	input wire logic [2*NREF-1:0] priority_i,
	input wire logic [NREF-1:0] valid_i,
	output logic found_o,
	output logic [1:0] sel_o
);

	// lowest priority value wins, lowest index on a tie
	always_comb
	begin
		found_o = 1'b0;
		sel_o = 2'h0;
		for (int i = 0; i < NREF; i++)
		begin
			if (enable_i[i] && valid_i[i])
			begin
				if (!found_o || priority_i[2*i +: 2] < priority_i[2*sel_o +: 2])
				begin
					found_o = 1'b1;
					sel_o = 2'(i);
				end
			end
		end
	end

endmodule : dprp_ref_select

/* core/dprp_profile_regs.sv */
// per-reference loop profile register bank for two digital loops, Avalon-MM slave
// assumes the master holds read or write with address and data until waitrequest is low
// What this block does
// R1 - holds a two-bit priority for reference input four, zero after reset and zero being the highest.
// R2 - bit 0 of the priority register enables reference input four; while clear the loop never tracks it.
// R3 - a 17-bit bandwidth factor in 0.1 Hz steps spans three bytes, its top bit in bit 0 of the third.
// R4 - software keeps the bandwidth below one twentieth of the phase-detector frequency.
// R5 - software avoids bandwidths below 50 Hz when the system clock comes from a crystal.
// R6 - bit 1 of the third bandwidth byte selects the high phase-margin filter, clear selects normal.
// R7 - software should pick the high phase-margin filter above 2 kHz.
// R8 - an 18-bit integer divider minus one spans three bytes, its top two bits in bits 1:0 of the third.
// R9 - a 24-bit fraction numerator spans three bytes, low byte first, reset to zero.
// R10 - a 24-bit fraction denominator spans three bytes, low byte first, reset to zero.
// R11 - loop one repeats loop zero's registers 0x0100 higher with the same reset values.
// R12 - division is stored integer plus one plus numerator over denominator, for reference input four whether or not it is tracked.
// R13 - among enabled valid references the lowest priority value is preferred.
`timescale 1ns/10ps
module dprp_profile_regs #(
	parameter int NLOOP = 2,
	parameter int ADDR_W = 14
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [4*NLOOP-1:0] ref_valid_i,
	input wire logic [3*NLOOP-1:0] other_ref_enable_i,
	input wire logic [6*NLOOP-1:0] other_ref_priority_i,
	output logic [NLOOP-1:0] ref_found_o,
	output logic [2*NLOOP-1:0] ref_selected_o,
	output logic [NLOOP-1:0] ref4_tracked_o,
	output logic [17*NLOOP-1:0] loop_bandwidth_o,
	output logic [NLOOP-1:0] high_pm_filter_o,
	output logic [19*NLOOP-1:0] fb_divide_int_o,
	output logic [24*NLOOP-1:0] fb_numerator_o,
	output logic [24*NLOOP-1:0] fb_denominator_o,
	output logic [24*NLOOP-1:0] ref3_fb_denominator_o
);

	localparam int NSLOT = dprp_pkg::BANK_SLOTS;

	logic [7:0] regs_ff [0:NLOOP*NSLOT-1];
	logic [31:0] avs_readdata_ff;
	logic avs_waitrequest_ff;
	logic [NLOOP-1:0] ref_found_ff;
	logic [2*NLOOP-1:0] ref_selected_ff;
	logic [NLOOP-1:0] ref4_tracked_ff;
	logic [17*NLOOP-1:0] loop_bandwidth_ff;
	logic [NLOOP-1:0] high_pm_filter_ff;
	logic [19*NLOOP-1:0] fb_divide_int_ff;
	logic [24*NLOOP-1:0] fb_numerator_ff;
	logic [24*NLOOP-1:0] fb_denominator_ff;
	logic [24*NLOOP-1:0] ref3_fb_denominator_ff;

	// address decode
	wire [11:0] word_idx = avs_address_i[13:2];
	wire bus_req = avs_read_i || avs_write_i;
	wire accept = bus_req && !avs_waitrequest_ff;
	wire [NLOOP-1:0] bank_hit;
	wire [NLOOP-1:0] status_hit;
	wire [3:0] slot_sel [0:NLOOP-1];
	wire [NLOOP-1:0] sel_found;
	wire [1:0] sel_idx [0:NLOOP-1];
	wire [7:0] rd_byte;
	wire [NLOOP-1:0] rd_bank_hit;

	// profile bytes gathered into fields
	function automatic logic [23:0] three_bytes(input int base, input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2);
		three_bytes = {b2, b1, b0};
	endfunction : three_bytes

	genvar l;
	generate
		for (l = 0; l < NLOOP; l++)
		begin : g_loop
			localparam logic [11:0] BASE = 12'(dprp_pkg::IDX_BANK_BASE + 12'(l) * dprp_pkg::IDX_LOOP_STRIDE);
			localparam logic [11:0] STAT = 12'(dprp_pkg::IDX_LOOP_STATUS + 12'(l) * dprp_pkg::IDX_LOOP_STRIDE);
			localparam int O = l * NSLOT;
			wire [11:0] rel = 12'(word_idx - BASE);
			wire [7:0] prio_reg = regs_ff[O + dprp_pkg::SLOT_PRIO_EN];
			wire [23:0] bw_raw = three_bytes(0, regs_ff[O + dprp_pkg::SLOT_BW_B0],
				regs_ff[O + dprp_pkg::SLOT_BW_B1], regs_ff[O + dprp_pkg::SLOT_BW_B2]);
			wire [23:0] int_raw = three_bytes(0, regs_ff[O + dprp_pkg::SLOT_INT_B0],
				regs_ff[O + dprp_pkg::SLOT_INT_B1], regs_ff[O + dprp_pkg::SLOT_INT_B2]);
			wire [23:0] num_raw = three_bytes(0, regs_ff[O + dprp_pkg::SLOT_NUM_B0],
				regs_ff[O + dprp_pkg::SLOT_NUM_B0 + 1], regs_ff[O + dprp_pkg::SLOT_NUM_B0 + 2]);
			wire [23:0] den_raw = three_bytes(0, regs_ff[O + dprp_pkg::SLOT_DEN_B0],
				regs_ff[O + dprp_pkg::SLOT_DEN_B0 + 1], regs_ff[O + dprp_pkg::SLOT_DEN_B0 + 2]);
			wire [23:0] ref3_den_raw = three_bytes(0, regs_ff[O + dprp_pkg::SLOT_REF3_DEN_B0],
				regs_ff[O + dprp_pkg::SLOT_REF3_DEN_B0 + 1], regs_ff[O + dprp_pkg::SLOT_REF3_DEN_B0 + 2]);
			wire [3:0] en_vec = {prio_reg[dprp_pkg::POS_ENABLE], other_ref_enable_i[3*l +: 3]};
			wire [7:0] prio_vec = {prio_reg[dprp_pkg::POS_PRIO_LO +: 2], other_ref_priority_i[6*l +: 6]};
			wire tracks_ref4 = sel_found[l] && sel_idx[l] == 2'(dprp_pkg::REF4_INDEX);

			// R11 loop one bank offset
			assign bank_hit[l] = word_idx >= BASE && rel < 12'(NSLOT);
			assign status_hit[l] = word_idx == STAT;
			assign slot_sel[l] = rel[3:0];
			assign rd_bank_hit[l] = bank_hit[l] && avs_read_i;

			// R13 priority selection
			dprp_ref_select #(
				.NREF(dprp_pkg::NUM_REFS)
			) u_sel (
				.enable_i(en_vec),
				.priority_i(prio_vec),
				.valid_i(ref_valid_i[4*l +: 4]),
				.found_o(sel_found[l]),
				.sel_o(sel_idx[l])
			);

			always_ff @(posedge ref_clk_i)
			begin
				if (!reset_n_i)
				begin
					ref_found_ff[l] <= 1'b0;
					ref_selected_ff[2*l +: 2] <= 2'h0;
					ref4_tracked_ff[l] <= 1'b0;
					loop_bandwidth_ff[17*l +: 17] <= 17'h00000;
					high_pm_filter_ff[l] <= 1'b0;
					fb_divide_int_ff[19*l +: 19] <= 19'h00000;
					fb_numerator_ff[24*l +: 24] <= 24'h000000;
					fb_denominator_ff[24*l +: 24] <= 24'h000000;
					ref3_fb_denominator_ff[24*l +: 24] <= 24'h000000;
				end
				else
				begin
					ref_found_ff[l] <= sel_found[l];
					ref_selected_ff[2*l +: 2] <= sel_idx[l];
					// R2 enable gates tracking
					ref4_tracked_ff[l] <= tracks_ref4;
					// R3 17-bit bandwidth factor
					loop_bandwidth_ff[17*l +: 17] <= bw_raw[16:0];
					// R6 base filter choice
					high_pm_filter_ff[l] <= bw_raw[16 + dprp_pkg::POS_FILTER_SEL];
					// R8 R12 stored integer plus one
					fb_divide_int_ff[19*l +: 19] <= 19'({1'b0, int_raw[17:0]} + 19'h00001);
					// R9 numerator low byte first
					fb_numerator_ff[24*l +: 24] <= num_raw;
					// R10 denominator low byte first
					fb_denominator_ff[24*l +: 24] <= den_raw;
					ref3_fb_denominator_ff[24*l +: 24] <= ref3_den_raw;
				end
			end
		end
	endgenerate

	// read data mux
	wire [3:0] rd_slot = rd_bank_hit[1] ? slot_sel[1] : slot_sel[0];
	wire rd_loop = rd_bank_hit[1];
	assign rd_byte = regs_ff[{27'h0000000, rd_loop} * NSLOT + {28'h0000000, rd_slot}];
	wire [31:0] status_word0 = {28'h0000000, ref4_tracked_ff[0], ref_found_ff[0], ref_selected_ff[1:0]};
	wire [31:0] status_word1 = {28'h0000000, ref4_tracked_ff[1], ref_found_ff[1], ref_selected_ff[3:2]};
	wire [31:0] rd_word;
	assign rd_word = (|bank_hit) ? {24'h000000, rd_byte} :
		status_hit[0] ? status_word0 :
		status_hit[1] ? status_word1 :
		32'h00000000;

	// one wait cycle per access
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			avs_waitrequest_ff <= 1'b1;
			avs_readdata_ff <= 32'h00000000;
		end
		else
		begin
			avs_waitrequest_ff <= !(bus_req && avs_waitrequest_ff);
			if (avs_read_i && avs_waitrequest_ff)
				avs_readdata_ff <= rd_word;
		end
	end

	// register writes with byte lane 0 and reserved bits masked
	always_ff @(posedge ref_clk_i)
	begin
		for (int i = 0; i < NLOOP * NSLOT; i++)
		begin
			if (!reset_n_i)
				regs_ff[i] <= dprp_pkg::RESET_BYTE;
			else if (accept && avs_write_i && avs_byteenable_i[0] && bank_hit[i / NSLOT]
				&& slot_sel[i / NSLOT] == 4'(i % NSLOT))
				regs_ff[i] <= avs_writedata_i[7:0] & dprp_pkg::slot_mask(i % NSLOT);
		end
	end

	assign avs_readdata_o = avs_readdata_ff;
	assign avs_waitrequest_o = avs_waitrequest_ff;
	assign ref_found_o = ref_found_ff;
	assign ref_selected_o = ref_selected_ff;
	assign ref4_tracked_o = ref4_tracked_ff;
	assign loop_bandwidth_o = loop_bandwidth_ff;
	assign high_pm_filter_o = high_pm_filter_ff;
	assign fb_divide_int_o = fb_divide_int_ff;
	assign fb_numerator_o = fb_numerator_ff;
	assign fb_denominator_o = fb_denominator_ff;
	assign ref3_fb_denominator_o = ref3_fb_denominator_ff;

	// checks on loop zero and the loop one bank
	wire wr_take = accept && avs_write_i && avs_byteenable_i[0];
	wire [7:0] prio0 = regs_ff[dprp_pkg::SLOT_PRIO_EN];

	sequence s_write_at(logic [11:0] idx);
		wr_take && word_idx == idx;
	endsequence

	// R1 priority field write
	property p_prio_write;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_PRIO_EN) |=> prio0[2:1] == $past(avs_writedata_i[2:1]) && prio0[7:3] == 5'h00;
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority field not stored"); // R1

	// R2 disabled reference never tracked
	property p_no_track_disabled;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		!prio0[dprp_pkg::POS_ENABLE] |=> !ref4_tracked_ff[0];
	endproperty
	a_no_track_disabled: assert property (p_no_track_disabled) else $error("disabled reference tracked"); // R2

	// R3 bandwidth top bit
	property p_bw_top;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_BW_B2_FILT) ##2 1'b1 |-> loop_bandwidth_ff[16] == $past(avs_writedata_i[0], 2);
	endproperty
	a_bw_top: assert property (p_bw_top) else $error("bandwidth bit 16 wrong"); // R3

	// R6 filter select follows bit 1
	property p_filter_sel;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_BW_B2_FILT) ##2 1'b1 |-> high_pm_filter_ff[0] == $past(avs_writedata_i[1], 2);
	endproperty
	a_filter_sel: assert property (p_filter_sel) else $error("filter select wrong"); // R6

	// R8 R12 divide is stored plus one
	property p_div_plus_one;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_INT_B0) ##2 1'b1 |->
			fb_divide_int_ff[7:0] == 8'($past(avs_writedata_i[7:0], 2) + 8'h01);
	endproperty
	a_div_plus_one: assert property (p_div_plus_one) else $error("integer divide not plus one"); // R8

	// R9 numerator top byte
	property p_num_top;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_NUM_B2) ##2 1'b1 |-> fb_numerator_ff[23:16] == $past(avs_writedata_i[7:0], 2);
	endproperty
	a_num_top: assert property (p_num_top) else $error("numerator top byte wrong"); // R9

	// R10 denominator low byte
	property p_den_low;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(dprp_pkg::IDX_REF4_DEN_B0) ##2 1'b1 |-> fb_denominator_ff[7:0] == $past(avs_writedata_i[7:0], 2);
	endproperty
	a_den_low: assert property (p_den_low) else $error("denominator low byte wrong"); // R10

	// R11 loop one write leaves loop zero
	property p_loop1_bank;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_write_at(12'(dprp_pkg::IDX_REF4_PRIO_EN + dprp_pkg::IDX_LOOP_STRIDE)) |=>
			regs_ff[NSLOT + dprp_pkg::SLOT_PRIO_EN] == ($past(avs_writedata_i[7:0]) & dprp_pkg::MASK_PRIO_EN)
			&& $stable(prio0);
	endproperty
	a_loop1_bank: assert property (p_loop1_bank) else $error("loop one bank misplaced"); // R11

	// R13 reference zero, if enabled and valid, holds no lower priority value
	property p_best_prio;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		ref4_tracked_ff[0] |-> $past(!(other_ref_enable_i[0] && ref_valid_i[0]
			&& other_ref_priority_i[1:0] < prio0[2:1]));
	endproperty
	a_best_prio: assert property (p_best_prio) else $error("lower priority value ignored"); // R13

	sequence s_read_done;
		avs_read_i && !avs_waitrequest_ff;
	endsequence

	// bus answers after exactly one wait cycle
	property p_one_wait;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(bus_req && avs_waitrequest_ff) |=> !avs_waitrequest_ff ##1 avs_waitrequest_ff;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");

	// reserved priority bits read zero
	property p_reserved_zero;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_read_done and (word_idx == dprp_pkg::IDX_REF4_PRIO_EN) |-> avs_readdata_ff[31:3] == 29'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // R1

endmodule : dprp_profile_regs

/* test/tb_top.sv */
// self-checking bench for the reference profile register bank, two loops
// assumes the bank answers one cycle after a request and derived outputs lag by one clock
`timescale 1ns/10ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [13:0] avs_address_i = 14'h0000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [3:0] avs_byteenable_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [7:0] ref_valid_i = 8'h00;
	logic [5:0] other_ref_enable_i = 6'h00;
	logic [11:0] other_ref_priority_i = 12'h000;
	logic [1:0] ref_found_o;
	logic [3:0] ref_selected_o;
	logic [1:0] ref4_tracked_o;
	logic [33:0] loop_bandwidth_o;
	logic [1:0] high_pm_filter_o;
	logic [37:0] fb_divide_int_o;
	logic [47:0] fb_numerator_o;
	logic [47:0] fb_denominator_o;
	logic [47:0] ref3_fb_denominator_o;
	logic [7:0] mem [2][16];
	int fail_count = 0;
	int n_checks = 0;

	always #2.5 ref_clk_i = ~ref_clk_i;

	dprp_profile_regs #(.NLOOP(2), .ADDR_W(14)) i_dprp_profile_regs (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .ref_valid_i(ref_valid_i), .other_ref_enable_i(other_ref_enable_i),
		.other_ref_priority_i(other_ref_priority_i), .ref_found_o(ref_found_o), .ref_selected_o(ref_selected_o),
		.ref4_tracked_o(ref4_tracked_o), .loop_bandwidth_o(loop_bandwidth_o), .high_pm_filter_o(high_pm_filter_o),
		.fb_divide_int_o(fb_divide_int_o), .fb_numerator_o(fb_numerator_o), .fb_denominator_o(fb_denominator_o),
		.ref3_fb_denominator_o(ref3_fb_denominator_o));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// writable bits of each slot
	function automatic logic [7:0] bmask(input int s);
		return (s == 3) ? 8'h07 : ((s == 6 || s == 9) ? 8'h03 : 8'hff);
	endfunction : bmask

	function automatic logic [11:0] ix(input int l, input int s);
		return dprp_pkg::IDX_BANK_BASE + dprp_pkg::IDX_LOOP_STRIDE * 12'(l) + 12'(s);
	endfunction : ix

	// {found, index} by lowest priority value, ties to lowest index
	function automatic logic [2:0] pick(input int l);
		logic [3:0] en;
		logic [3:0] vl;
		logic [7:0] pr;
		logic [2:0] r;
		int best;
		en = {mem[l][3][0], other_ref_enable_i[3*l +: 3]};
		pr = {mem[l][3][2:1], other_ref_priority_i[6*l +: 6]};
		vl = ref_valid_i[4*l +: 4];
		r = 3'b000;
		best = 4;
		for (int i = 0; i < 4; i++)
			if (en[i] && vl[i] && int'(pr[2*i +: 2]) < best)
			begin
				best = int'(pr[2*i +: 2]);
				r = {1'b1, 2'(i)};
			end
		return r;
	endfunction : pick

	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		int n;
		n = 0;
		avs_address_i <= {idx, 2'b00};
		avs_byteenable_i <= be;
		avs_writedata_i <= {24'($urandom), d};
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 16);
		if (n >= 16)
		begin
			fail_count++;
			$display("ERROR waitrequest expected 0 seen %b", avs_waitrequest_o);
			stop_test();
		end
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : bus

	task automatic rd_all;
		logic [31:0] rd;
		for (int l = 0; l < 2; l++)
			for (int s = 0; s < 16; s++)
			begin
				bus(1'b0, ix(l, s), 8'($urandom), 4'hf, rd);
				chk("register", {24'h0, mem[l][s]}, rd);
			end
		bus(1'b0, ix(0, 16), 8'h00, 4'hf, rd);
		chk("unmapped read", 32'h0, rd);
	endtask : rd_all

	task automatic chk_outs;
		logic [2:0] p;
		logic [31:0] st;
		for (int l = 0; l < 2; l++)
		begin
			p = pick(l);
			bus(1'b0, dprp_pkg::IDX_LOOP_STATUS + dprp_pkg::IDX_LOOP_STRIDE * 12'(l), 8'h00, 4'hf, st);
			chk("status", {28'h0, p == 3'b111, p}, st);
			chk("found", 32'(p[2]), 32'(ref_found_o[l]));
			if (p[2])
				chk("selected", 32'(p[1:0]), 32'(ref_selected_o[2*l +: 2]));
			chk("ref4 tracked", 32'(p == 3'b111), 32'(ref4_tracked_o[l]));
			chk("bandwidth", 32'({mem[l][6][0], mem[l][5], mem[l][4]}), 32'(loop_bandwidth_o[17*l +: 17]));
			chk("filter", 32'(mem[l][6][1]), 32'(high_pm_filter_o[l]));
			chk("divide", 32'({mem[l][9][1:0], mem[l][8], mem[l][7]}) + 32'h1, 32'(fb_divide_int_o[19*l +: 19]));
			chk("numerator", 32'({mem[l][12], mem[l][11], mem[l][10]}), 32'(fb_numerator_o[24*l +: 24]));
			chk("denominator", 32'({mem[l][15], mem[l][14], mem[l][13]}), 32'(fb_denominator_o[24*l +: 24]));
			chk("ref3 den", 32'({mem[l][2], mem[l][1], mem[l][0]}), 32'(ref3_fb_denominator_o[24*l +: 24]));
		end
	endtask : chk_outs

	task automatic do_reset;
		reset_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		for (int l = 0; l < 2; l++)
			for (int s = 0; s < 16; s++)
				mem[l][s] = 8'h00;
		repeat (2) @(posedge ref_clk_i);
		chk("waitrequest idle", 32'h1, 32'(avs_waitrequest_o));
		chk_outs();
		rd_all();
	endtask : do_reset

	initial
	begin
		logic [31:0] rd;
		logic [7:0] d;
		int s;
		void'($urandom(32'h03f7));
		do_reset();
		for (int round = 0; round < 6; round++)
		begin
			// software limits, bank stores any value
			for (int l = 0; l < 2; l++)
				for (int k = 0; k < 16; k++)
				begin
					d = (round == 0) ? 8'hff : 8'($urandom);
					bus(1'b1, ix(l, k), d, 4'h1 | 4'($urandom), rd);
					mem[l][k] = d & bmask(k);
				end
			// byte lane zero disabled: ignored
			s = $urandom_range(15);
			bus(1'b1, ix(0, s), ~mem[0][s], 4'he, rd);
			bus(1'b1, ix(1, 16), 8'h5a, 4'hf, rd);
			ref_valid_i <= 8'($urandom);
			other_ref_enable_i <= 6'($urandom);
			other_ref_priority_i <= 12'($urandom);
			repeat (3) @(posedge ref_clk_i);
			chk_outs();
			rd_all();
		end
		for (int it = 0; it < 48; it++)
		begin
			for (int l = 0; l < 2; l++)
			begin
				d = 8'($urandom);
				bus(1'b1, ix(l, 3), d, 4'hf, rd);
				mem[l][3] = d & 8'h07;
			end
			ref_valid_i <= (it < 4) ? 8'hff : 8'($urandom);
			other_ref_enable_i <= (it < 4) ? 6'h00 : 6'($urandom);
			other_ref_priority_i <= 12'($urandom);
			repeat (3) @(posedge ref_clk_i);
			chk_outs();
		end
		do_reset();
		stop_test();
	end
endmodule : tb_top
